// ### dv/csb_membus_model.sv
// Memory bus controller model answering sideband cycles
`timescale 1ns/10ps
module csb_membus_model (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic RESET,
  // Bench knobs
  input  wire logic SLOW,
  input  wire logic DM_N,
  // Sideband pins
  input  wire logic MEMBUS_CYCLE_STROBE_N,
  output logic      MEMBUS_READY_N,
  output logic      MEMBUS_GRANT_N,
  output logic      SNOOP_WINDOW_END_N,
  output logic      DIRECT_TO_MODIFIED_REQ_N,
  output logic      NEXT_CYCLE_ENABLE_N
);
  logic [3:0] n, t;
  logic       tog;
  wire  [3:0] lat  = SLOW ? 4'h8 : 4'h3;
  wire        busy = n != 4'h0;
  wire        done = busy && t >= lat;
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      n <= 4'h0;
      t <= 4'h0;
      tog <= 1'b0;
    end else begin
      n <= n + {3'h0, !MEMBUS_CYCLE_STROBE_N} - {3'h0, done};
      t <= (done || !busy) ? 4'h0 : t + 4'h1;
      tog <= ~tog;
    end
  end
  assign MEMBUS_READY_N = !done;
  assign MEMBUS_GRANT_N = !(busy && t == 4'h1);
  assign SNOOP_WINDOW_END_N = !(busy && t == 4'h2);
  // Outside the window the line toggles so a stale value is never trusted
  assign DIRECT_TO_MODIFIED_REQ_N = SNOOP_WINDOW_END_N ? tog : DM_N;
  assign NEXT_CYCLE_ENABLE_N = !(busy && t != 4'h0);
endmodule // csb_membus_model

// ### dv/csb_sideband_checker.sv
// Assertions on the sideband block pins
`timescale 1ns/10ps
module csb_sideband_checker (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Watched pins
  input wire logic STRONG_ORDER,
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire logic REQ_WAY,
  input wire logic MEMBUS_CYCLE_STROBE_N,
  input wire logic WAY_SELECT_OUT,
  input wire logic MEMBUS_GRANT_N,
  input wire logic SNOOP_WINDOW_END_N,
  input wire logic DIRECT_TO_MODIFIED_REQ_N,
  input wire csb_pkg::csb_line_t FILL_STATE,
  input wire logic FILL_STATE_VALID,
  input wire logic CPU_CYCLE_STROBE_N,
  input wire logic DATA_CODE,
  input wire logic CPU_MEM_IO,
  input wire csb_pkg::csb_cyc_t CPU_CYCLE_KIND,
  input wire logic CPU_CYCLE_VALID,
  input wire logic INQ_REQ,
  input wire logic INQ_ADDR_VALID,
  input wire logic INQ_ADDR_STROBE_N,
  input wire logic INQ_DONE,
  input wire logic WRITE_BUFFER_EMPTY_N
);
  import csb_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  wire take = REQ_VALID && REQ_READY;
  a_way_with_strobe: assert property (take |=>
    !MEMBUS_CYCLE_STROBE_N && WAY_SELECT_OUT == $past(REQ_WAY)) else $error("way or strobe");
  a_strobe_cause: assert property ($fell(MEMBUS_CYCLE_STROBE_N) |-> $past(take))
    else $error("strobe without take");
  a_strobe_pulse: assert property (!MEMBUS_CYCLE_STROBE_N |=> MEMBUS_CYCLE_STROBE_N)
    else $error("strobe too long");
  a_fill_state: assert property (!SNOOP_WINDOW_END_N |=> FILL_STATE_VALID &&
    FILL_STATE == ($past(DIRECT_TO_MODIFIED_REQ_N) ? 2'h2 : 2'h3)) else $error("fill state");
  a_cycle_kind: assert property (!CPU_CYCLE_STROBE_N |=> CPU_CYCLE_VALID &&
    CPU_CYCLE_KIND == ($past(DATA_CODE) ? CSB_CYC_DATA : $past(CPU_MEM_IO) ?
    CSB_CYC_CODE : CSB_CYC_SPECIAL)) else $error("cycle kind");
  a_inq_addr: assert property ($fell(INQ_ADDR_STROBE_N) |->
    INQ_DONE && $past(INQ_REQ && INQ_ADDR_VALID)) else $error("inquire strobe");
  a_weak_wbe: assert property (!STRONG_ORDER && !$past(STRONG_ORDER) |->
    !WRITE_BUFFER_EMPTY_N) else $error("weak order not empty");
  a_wbe_clear: assert property ($fell(WRITE_BUFFER_EMPTY_N) && $past(STRONG_ORDER) |->
    $past(!MEMBUS_GRANT_N)) else $error("empty without grant");
  cover property (take && STRONG_ORDER);
  cover property (!SNOOP_WINDOW_END_N && !DIRECT_TO_MODIFIED_REQ_N);
  cover property (!INQ_ADDR_STROBE_N);
endmodule // csb_sideband_checker

// ### dv/testbench.sv
// Self-checking bench for the cache sideband block
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
  $display("wrong value %0t got %h exp %h", $time, a, b); end end
module testbench;
  import csb_pkg::*;
  logic CLK = 0, RESET = 1, STRONG_ORDER = 1, REQ_VALID = 0, REQ_WAY = 0;
  logic REQ_WRITETHROUGH = 0, CPU_CYCLE_STROBE_N = 1, DATA_CODE = 0, CPU_MEM_IO = 0;
  logic INQ_REQ = 0, INQ_ADDR_VALID = 0, SLOW = 0, DM_N = 1, ew = 0, ef = 0, em = 0, ec = 0;
  logic REQ_READY, MEMBUS_CYCLE_STROBE_N, WAY_SELECT_OUT, FILL_STATE_VALID, CPU_CYCLE_VALID;
  logic NEXT_CYCLE_ENABLE_N, MEMBUS_READY_N, MEMBUS_GRANT_N, SNOOP_WINDOW_END_N;
  logic DIRECT_TO_MODIFIED_REQ_N, INQ_ADDR_STROBE_N, INQ_DONE, WRITE_BUFFER_EMPTY_N;
  csb_line_t FILL_STATE;
  csb_cyc_t CPU_CYCLE_KIND, ek;
  logic [31:0] seed = 32'h0000_7c0b;
  int num_errors = 0, comparisons = 0, cnt = 0;
  bit q[$];
  csb_sideband u_dut (.*);
  csb_membus_model u_mbc (.*);
  always #10 CLK = ~CLK;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  // Reference model: buffer-empty, fill state and cycle kind are checked at the edge after their cause
  always @(posedge CLK) if (RESET) cnt = 0; else begin
    `CHK(WRITE_BUFFER_EMPTY_N, ew)
    `CHK(FILL_STATE_VALID, ef)
    if (ef) `CHK(FILL_STATE, em ? 2'h3 : 2'h2)
    `CHK(CPU_CYCLE_VALID, ec)
    if (ec) `CHK(CPU_CYCLE_KIND, ek)
    if (REQ_VALID && REQ_READY) q.push_back(REQ_WRITETHROUGH);
    if (REQ_VALID && REQ_READY && REQ_WRITETHROUGH && cnt < 15) cnt++;
    if (!MEMBUS_GRANT_N && q.size() > 0 && q[0]) cnt--;
    if (!MEMBUS_READY_N) void'(q.pop_front());
    ew = STRONG_ORDER && cnt != 0;
    ef = !SNOOP_WINDOW_END_N;
    em = !DIRECT_TO_MODIFIED_REQ_N;
    ec = !CPU_CYCLE_STROBE_N;
    ek = DATA_CODE ? CSB_CYC_DATA : CPU_MEM_IO ? CSB_CYC_CODE : CSB_CYC_SPECIAL;
  end
  task automatic req(input logic w, input logic wt);
    int i;
    @(negedge CLK);
    REQ_VALID = 1;
    REQ_WAY = w;
    REQ_WRITETHROUGH = wt;
    for (i = 0; i < 50 && REQ_READY !== 1'b1; i++) @(negedge CLK);
    @(negedge CLK);
    `CHK(MEMBUS_CYCLE_STROBE_N, 1'b0)
    `CHK(WAY_SELECT_OUT, w)
    REQ_VALID = 0;
  endtask
  task automatic results;
    if (num_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge CLK);
    RESET = 0;
    for (int k = 0; k < 160; k++) begin
      seed = xs(seed);
      STRONG_ORDER = k < 110;
      SLOW = seed[3];
      DM_N = seed[4];
      CPU_CYCLE_STROBE_N = seed[5];
      DATA_CODE = seed[6];
      CPU_MEM_IO = seed[7];
      req(seed[1], seed[2] && WRITE_BUFFER_EMPTY_N !== 1'b1);
      if (k % 10 == 0) begin
        INQ_REQ = 1;
        repeat (2) begin @(negedge CLK); `CHK(INQ_ADDR_STROBE_N, 1'b1) end
        INQ_ADDR_VALID = 1;
        @(negedge CLK);
        `CHK(INQ_ADDR_STROBE_N, 1'b0)
        `CHK(INQ_DONE, 1'b1)
        INQ_REQ = 0;
        INQ_ADDR_VALID = 0;
      end
    end
    repeat (20) @(negedge CLK);
    results;
  end
  initial begin
    #500000;
    num_errors++;
    results;
  end
endmodule // testbench
bind csb_sideband csb_sideband_checker u_chk (.*);

// ### hdl/csb_sideband.sv
// Cache controller sideband signalling toward memory bus and processor
`timescale 1ns/10ps
`include "csb_defines.svh"
module csb_sideband (
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RESET,
  // Configuration
  input  wire logic              STRONG_ORDER,
  // Internal cycle request
  input  wire logic              REQ_VALID,
  output logic                   REQ_READY,
  input  wire logic              REQ_WAY,
  input  wire logic              REQ_WRITETHROUGH,
  // Memory bus side
  output logic                   MEMBUS_CYCLE_STROBE_N,
  output logic                   WAY_SELECT_OUT,
  input  wire logic              NEXT_CYCLE_ENABLE_N,
  input  wire logic              MEMBUS_READY_N,
  input  wire logic              MEMBUS_GRANT_N,
  input  wire logic              SNOOP_WINDOW_END_N,
  input  wire logic              DIRECT_TO_MODIFIED_REQ_N,
  output csb_pkg::csb_line_t     FILL_STATE,
  output logic                   FILL_STATE_VALID,
  // Processor side
  input  wire logic              CPU_CYCLE_STROBE_N,
  input  wire logic              DATA_CODE,
  input  wire logic              CPU_MEM_IO,
  output csb_pkg::csb_cyc_t      CPU_CYCLE_KIND,
  output logic                   CPU_CYCLE_VALID,
  input  wire logic              INQ_REQ,
  input  wire logic              INQ_ADDR_VALID,
  output logic                   INQ_ADDR_STROBE_N,
  output logic                   INQ_DONE,
  output logic                   WRITE_BUFFER_EMPTY_N
);
  import csb_pkg::*;

  // ----------------------------------------
  // Memory bus cycle sequencer
  // ----------------------------------------
  csb_mstate_t state;
  csb_mstate_t next_state;
  logic        pend_wt;
  logic        pend_valid;
  logic        issue_wt;
  csb_wb_if    wbl ();

  wire cna      = !NEXT_CYCLE_ENABLE_N;
  wire done     = !MEMBUS_READY_N;
  // New strobe allowed when idle or pipelined behind a pending cycle
  wire can_issue = (state == CSB_IDLE) || ((state == CSB_PENDING) && cna && !pend_valid);
  wire take     = REQ_VALID && can_issue;
  assign REQ_READY = can_issue;

  always_comb begin
    next_state = state;
    unique case (state)
      CSB_IDLE:    if (take) next_state = CSB_ISSUE;
      CSB_ISSUE:   next_state = CSB_PENDING;
      CSB_PENDING: if (take) next_state = CSB_ISSUE;
                   else if (done && !pend_valid) next_state = CSB_IDLE;
      default:     next_state = CSB_IDLE;
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state                 <= CSB_IDLE;
      MEMBUS_CYCLE_STROBE_N <= 1'b1;
      WAY_SELECT_OUT        <= `CSB_WAY0;
    end else begin
      state                 <= next_state;
      MEMBUS_CYCLE_STROBE_N <= !take;
      if (take) begin
        WAY_SELECT_OUT <= REQ_WAY;
      end
    end
  end

  // One cycle may sit pipelined behind the active one; it ends on ready.
  // A take in the very clock the head ends makes the new cycle the head.
  wire queue_it = take && (state == CSB_PENDING) && !done;
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pend_valid <= 1'b0;
      pend_wt    <= 1'b0;
      issue_wt   <= 1'b0;
    end else begin
      if (queue_it) begin
        pend_valid <= 1'b1;
        pend_wt    <= REQ_WRITETHROUGH;
      end else if (done) begin
        pend_valid <= 1'b0;
      end
      // Grant belongs to the head cycle, not to the queued one
      if (take && !queue_it) begin
        issue_wt <= REQ_WRITETHROUGH;
      end else if (done && pend_valid) begin
        issue_wt <= pend_wt;
      end
    end
  end

  // ----------------------------------------
  // Write ordering
  // ----------------------------------------
  assign wbl.post  = take && REQ_WRITETHROUGH;
  assign wbl.grant = !MEMBUS_GRANT_N && (state != CSB_IDLE) && issue_wt;

  csb_wb_track u_track (
    .CLK                  (CLK),
    .RESET                (RESET),
    .strong_order         (STRONG_ORDER),
    .wb                   (wbl),
    .write_buffer_empty_n (WRITE_BUFFER_EMPTY_N)
  );

  // ----------------------------------------
  // Line state promotion
  // ----------------------------------------
  // Sampling only at window end keeps a stray level from changing state
  wire snoop_window_end_n = !SNOOP_WINDOW_END_N;
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      FILL_STATE       <= `CSB_LINE_I;
      FILL_STATE_VALID <= 1'b0;
    end else begin
      FILL_STATE_VALID <= snoop_window_end_n;
      if (snoop_window_end_n) begin
        FILL_STATE <= !DIRECT_TO_MODIFIED_REQ_N ? `CSB_LINE_M : `CSB_LINE_E;
      end
    end
  end

  // ----------------------------------------
  // Processor cycle decode
  // ----------------------------------------
  // Qualifier is trusted only in the strobe clock
  wire      cpu_start = !CPU_CYCLE_STROBE_N;
  csb_cyc_t kind_w;
  assign kind_w = DATA_CODE ? CSB_CYC_DATA :
                  (CPU_MEM_IO ? CSB_CYC_CODE : CSB_CYC_SPECIAL);

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      CPU_CYCLE_KIND  <= CSB_CYC_CODE;
      CPU_CYCLE_VALID <= 1'b0;
    end else begin
      CPU_CYCLE_VALID <= cpu_start;
      if (cpu_start) begin
        CPU_CYCLE_KIND <= kind_w;
      end
    end
  end

  // ----------------------------------------
  // Inquire and back-invalidation strobe
  // ----------------------------------------
  // Held request fires once the address has settled on the pins
  logic inq_busy;
  wire  inq_fire = INQ_REQ && INQ_ADDR_VALID && !inq_busy;
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      INQ_ADDR_STROBE_N <= 1'b1;
      INQ_DONE          <= 1'b0;
      inq_busy          <= 1'b0;
    end else begin
      INQ_ADDR_STROBE_N <= !inq_fire;
      INQ_DONE          <= inq_fire;
      inq_busy          <= INQ_REQ && (inq_busy || inq_fire);
    end
  end
endmodule // csb_sideband

// ### hdl/csb_wb_track.sv
// Posted writethrough tracker driving the write-buffer-empty indication
`timescale 1ns/10ps
`include "csb_defines.svh"
module csb_wb_track (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic RESET,
  // Mode
  input  wire logic strong_order,
  // Write events
  csb_wb_if.trk     wb,
  // Result
  output logic      write_buffer_empty_n
);
  logic [`CSB_CNT_W-1:0] posted;
  logic [`CSB_CNT_W-1:0] next_posted;
  wire inc = wb.post && !wb.grant && (posted != `CSB_CNT_MAX);
  wire dec = wb.grant && !wb.post && (posted != `CSB_CNT_ZERO);

  assign next_posted = inc ? posted + `CSB_CNT_ONE :
                       dec ? posted - `CSB_CNT_ONE : posted;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      posted <= `CSB_CNT_ZERO;
    end else begin
      posted <= next_posted;
    end
  end

  // Weak ordering never holds the processor back
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      write_buffer_empty_n <= 1'b0;
    end else begin
      write_buffer_empty_n <= strong_order && (next_posted != `CSB_CNT_ZERO);
    end
  end
endmodule // csb_wb_track

// ### inc/csb_defines.svh
// Constants for the cache sideband block
`ifndef CSB_DEFINES_SVH
`define CSB_DEFINES_SVH
`define CSB_WAY0         1'h0
`define CSB_WAY1         1'h1
`define CSB_CNT_W        4
`define CSB_CNT_ZERO     4'h0
`define CSB_CNT_ONE      4'h1
`define CSB_CNT_MAX      4'hF
`define CSB_LINE_M       2'h3
`define CSB_LINE_E       2'h2
`define CSB_LINE_S       2'h1
`define CSB_LINE_I       2'h0
`endif

// ### inc/csb_pkg.sv
// Types for the cache sideband block
package csb_pkg;
  typedef enum logic [2:0] {
    CSB_IDLE    = 3'b001,
    CSB_ISSUE   = 3'b010,
    CSB_PENDING = 3'b100
  } csb_mstate_t;
  typedef logic [1:0] csb_line_t;
  typedef enum logic [1:0] {
    CSB_CYC_CODE    = 2'b00,
    CSB_CYC_DATA    = 2'b01,
    CSB_CYC_SPECIAL = 2'b10
  } csb_cyc_t;
endpackage

// ### inc/csb_wb_if.sv
// Link between the memory cycle sequencer and the write-order tracker
`timescale 1ns/10ps
interface csb_wb_if;
  logic post;
  logic grant;
  modport seq (output post, output grant);
  modport trk (input post, input grant);
endinterface
